// ### cpg_pkg.sv
// Operation
// - Period counter is 8 or 16 bits
// - Count down from period, reload at zero
// - Center mode counts up then down
// - Two-output mode drives both compare outputs
// - Dual edge output is compare AND
// - Select input picks first or second compare
// - Dither second compare is value plus one
// - Dither picks second for offset periods
// - Five selectable compare relations per unit
// - Runtime compare relation only if firmware-controlled
// - Dead band makes two phase outputs
// - Dead time register only in wide variant
// - Enable by software, hardware or both
// - Continuous runs on, single shot stops
// - Multi trigger halts each period end
// - Trigger edge selectable, none means always
// - Asynchronous kill blocks while kill active
// - Single-cycle kill releases at terminal count
// - Latched kill holds until reset
// - Minimum-time kill holds for kill time
// - Terminal count high while counter zero
// - Trigger registered, counting starts one clock later
package cpg_pkg;

  // -----------------------------------------------------------------
  // Register map, word aligned byte offsets.
  // -----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_PERIOD = 8'h08;
  localparam logic [7:0] A_CMP1 = 8'h0c;
  localparam logic [7:0] A_CMP2 = 8'h10;
  localparam logic [7:0] A_DEAD = 8'h14;
  localparam logic [7:0] A_KILLT = 8'h18;
  localparam logic [7:0] A_COUNT = 8'h1c;
  localparam logic [7:0] A_STAT = 8'h20;

  // -----------------------------------------------------------------
  // Reset values and fixed build-time figures.
  // -----------------------------------------------------------------
  localparam logic [15:0] NARROW_MASK = 16'h00ff;
  localparam logic [15:0] RST_PERIOD = 16'h00ff;
  localparam logic [15:0] RST_CMP1 = 16'h0080;
  localparam logic [15:0] RST_CMP2 = 16'h0040;
  localparam logic [7:0] RST_DEAD = 8'h01;
  localparam logic [7:0] RST_KILLT = 8'h01;
  localparam logic [8:0] DB03_CYCLES = 9'h003;
  localparam logic [8:0] DB24_CYCLES = 9'h002;

  // -----------------------------------------------------------------
  // Enumerations.
  // -----------------------------------------------------------------
  typedef enum logic [2:0] {CPG_LT = 3'h0, CPG_LE = 3'h1, CPG_GT = 3'h2,
    CPG_GE = 3'h3, CPG_EQ = 3'h4} cpg_cmp_t;
  typedef enum logic [2:0] {CPG_ONE = 3'h0, CPG_TWO = 3'h1, CPG_DUAL = 3'h2,
    CPG_CENTER = 3'h3, CPG_DITHER = 3'h4, CPG_HWSEL = 3'h5} cpg_mode_t;
  typedef enum logic [1:0] {CPG_EN_SW = 2'h0, CPG_EN_HW = 2'h1,
    CPG_EN_BOTH = 2'h2} cpg_en_t;
  typedef enum logic [1:0] {CPG_CONT = 2'h0, CPG_SINGLE = 2'h1,
    CPG_MULTI = 2'h2} cpg_run_t;
  typedef enum logic [1:0] {CPG_TR_NONE = 2'h0, CPG_TR_RISE = 2'h1,
    CPG_TR_FALL = 2'h2, CPG_TR_EITHER = 2'h3} cpg_trig_t;
  typedef enum logic [2:0] {CPG_K_OFF = 3'h0, CPG_K_ASYNC = 3'h1,
    CPG_K_CYCLE = 3'h2, CPG_K_LATCH = 3'h3, CPG_K_MIN = 3'h4} cpg_kill_t;
  typedef enum logic [1:0] {CPG_DB_OFF = 2'h0, CPG_DB_03 = 2'h1,
    CPG_DB_24 = 2'h2, CPG_DB_256 = 2'h3} cpg_db_t;
  typedef enum logic [1:0] {CPG_ST_IDLE = 2'b00, CPG_ST_RUN = 2'b01,
    CPG_ST_DONE = 2'b11} cpg_state_t;

  // Compare relations used while firmware control is off.
  localparam cpg_cmp_t FIX_T1 = CPG_LT;
  localparam cpg_cmp_t FIX_T2 = CPG_LT;

  // -----------------------------------------------------------------
  // Register layouts.
  // -----------------------------------------------------------------
  typedef struct packed {
    logic narrow;
    logic [1:0] dither;
    cpg_kill_t kill;
    cpg_trig_t trig;
    cpg_run_t run;
    cpg_en_t en_mode;
    cpg_mode_t mode;
    logic sw_en;
  } cpg_ctrl_t;

  typedef struct packed {
    logic [6:0] rsvd;
    cpg_db_t db;
    logic fw;
    cpg_cmp_t t2;
    cpg_cmp_t t1;
  } cpg_cfg_t;

endpackage

// ### cpg_top.sv
// The register offsets and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
module cpg_top (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic [7:0] addr_in,
  input wire logic [15:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [15:0] rd_data_out,
  input wire logic hw_enable_in,
  input wire logic trigger_in,
  input wire logic kill_in,
  input wire logic output_select_in,
  output logic first_compare_output_out,
  output logic second_compare_output_out,
  output logic dead_band_phase_a_out,
  output logic dead_band_phase_b_out,
  output logic terminal_count_flag_out
);

  // -----------------------------------------------------------------
  // Helpers.
  // -----------------------------------------------------------------
  // One compare unit: counter against value under the chosen relation.
  function automatic logic cmp_f(input logic [15:0] c,
    input logic [15:0] v, input cpg_pkg::cpg_cmp_t t);
    logic r;
    r = 1'b0;
    unique case (t)
      cpg_pkg::CPG_LT: r = c < v;
      cpg_pkg::CPG_LE: r = c <= v;
      cpg_pkg::CPG_GT: r = c > v;
      cpg_pkg::CPG_GE: r = c >= v;
      cpg_pkg::CPG_EQ: r = c == v;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  // -----------------------------------------------------------------
  // Register state.
  // -----------------------------------------------------------------
  cpg_pkg::cpg_ctrl_t ctrl, next_ctrl; // Modes and software enable.
  cpg_pkg::cpg_cfg_t cfg, next_cfg; // Compare types and dead band.
  logic [15:0] period, next_period; // Period, software side.
  logic [15:0] cmp1, next_cmp1; // First compare, software side.
  logic [15:0] cmp2, next_cmp2; // Second compare, software side.
  logic [7:0] dead, next_dead; // Dead time, wide variant only.
  logic [7:0] killt, next_killt; // Minimum kill time.
  logic [15:0] next_rd; // Read data for the next cycle.

  // -----------------------------------------------------------------
  // Core state.
  // -----------------------------------------------------------------
  logic [2:0] sync_en, sync_tr, sync_kl, sync_sel; // Pin synchronisers.
  logic tr_q, next_tr_q; // Trigger history for edges.
  cpg_pkg::cpg_state_t state, next_state; // Run state.
  logic [15:0] cnt, next_cnt; // Period counter.
  logic up, next_up; // Center mode direction.
  logic [15:0] s1, next_s1, s2, next_s2; // Compare shadows.
  logic [1:0] dph, next_dph; // Dither period index.
  logic kflag, next_kflag; // Kill memory.
  logic [7:0] kcnt, next_kcnt; // Minimum kill countdown.
  logic src_q, next_src_q; // Dead band source history.
  logic [8:0] dbc, next_dbc; // Cycles since last source change.
  logic next_o1, next_o2, next_pa, next_pb, next_tc;

  // Combinational terms shared by the processes and assertions.
  logic en, tr_ev, ks, sel, adv, tc_now, pend, blk, c1, c2, a_raw, b_raw;
  logic [15:0] per;
  logic [8:0] dlen;
  cpg_pkg::cpg_cmp_t t1, t2;

  assign ks = sync_kl[2];
  assign sel = sync_sel[2];

  // -----------------------------------------------------------------
  // Register file.
  // -----------------------------------------------------------------
  // Writes store, reads present data only in the following cycle.
  always_comb begin
    next_ctrl = ctrl;
    next_cfg = cfg;
    next_period = period;
    next_cmp1 = cmp1;
    next_cmp2 = cmp2;
    next_dead = dead;
    next_killt = killt;
    next_rd = 16'h0000;
    if (wr_in) begin
      unique case (addr_in)
        cpg_pkg::A_CTRL: next_ctrl = cpg_pkg::cpg_ctrl_t'(wr_data_in);
        cpg_pkg::A_CFG: next_cfg = cpg_pkg::cpg_cfg_t'(wr_data_in);
        cpg_pkg::A_PERIOD: next_period = wr_data_in;
        cpg_pkg::A_CMP1: next_cmp1 = wr_data_in;
        cpg_pkg::A_CMP2: next_cmp2 = wr_data_in;
        cpg_pkg::A_DEAD: begin
          // Only the wide variant exposes a dead time to software.
          if (cfg.db == cpg_pkg::CPG_DB_256) begin
            next_dead = wr_data_in[7:0];
          end
        end
        cpg_pkg::A_KILLT: next_killt = wr_data_in[7:0];
        default: next_ctrl = ctrl;
      endcase
    end
    if (rd_in) begin
      unique case (addr_in)
        cpg_pkg::A_CTRL: next_rd = ctrl;
        cpg_pkg::A_CFG: next_rd = {7'h00, cfg[8:0]};
        cpg_pkg::A_PERIOD: next_rd = period;
        cpg_pkg::A_CMP1: next_rd = cmp1;
        cpg_pkg::A_CMP2: next_rd = cmp2;
        cpg_pkg::A_DEAD: begin
          if (cfg.db == cpg_pkg::CPG_DB_256) begin
            next_rd = {8'h00, dead};
          end
        end
        cpg_pkg::A_KILLT: next_rd = {8'h00, killt};
        cpg_pkg::A_COUNT: next_rd = cnt;
        cpg_pkg::A_STAT: next_rd = {12'h000, kflag, state, tc_now};
        default: next_rd = 16'h0000;
      endcase
    end
  end

  // Registers only; the period, compare, dead and kill time reset values sit in the package.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      ctrl <= cpg_pkg::cpg_ctrl_t'(16'h0000);
      cfg <= cpg_pkg::cpg_cfg_t'(16'h0000);
      period <= cpg_pkg::RST_PERIOD;
      cmp1 <= cpg_pkg::RST_CMP1;
      cmp2 <= cpg_pkg::RST_CMP2;
      dead <= cpg_pkg::RST_DEAD;
      killt <= cpg_pkg::RST_KILLT;
      rd_data_out <= 16'h0000;
    end else begin
      ctrl <= next_ctrl;
      cfg <= next_cfg;
      period <= next_period;
      cmp1 <= next_cmp1;
      cmp2 <= next_cmp2;
      dead <= next_dead;
      killt <= next_killt;
      rd_data_out <= next_rd;
    end
  end

  // -----------------------------------------------------------------
  // Counter, run control, compare, kill and dead band.
  // -----------------------------------------------------------------
  // One process works out every next value of the core.
  always_comb begin
    // Narrow control bit masks the period, and so the counter, to 8 bits.
    per = ctrl.narrow ? (period & cpg_pkg::NARROW_MASK) : period;
    unique case (ctrl.en_mode)
      cpg_pkg::CPG_EN_HW: en = sync_en[2];
      cpg_pkg::CPG_EN_BOTH: en = sync_en[2] & ctrl.sw_en;
      default: en = ctrl.sw_en;
    endcase
    // Trigger is read from the synchronised copy, three clocks late.
    unique case (ctrl.trig)
      cpg_pkg::CPG_TR_RISE: tr_ev = sync_tr[2] & ~tr_q;
      cpg_pkg::CPG_TR_FALL: tr_ev = ~sync_tr[2] & tr_q;
      cpg_pkg::CPG_TR_EITHER: tr_ev = sync_tr[2] ^ tr_q;
      default: tr_ev = 1'b1;
    endcase
    next_tr_q = sync_tr[2];
    tc_now = cnt == 16'h0000;
    adv = en && state == cpg_pkg::CPG_ST_RUN;
    next_cnt = cnt;
    next_up = up;
    if (adv) begin
      if (ctrl.mode == cpg_pkg::CPG_CENTER) begin
        // Up to the period, then back to zero: twice the period value in cycles.
        if (tc_now) begin
          next_cnt = 16'h0001;
          next_up = 1'b1;
        end else if (up) begin
          next_cnt = cnt + 16'h0001;
          next_up = (cnt + 16'h0001) != per;
        end else begin
          next_cnt = cnt - 16'h0001;
        end
      end else begin
        next_cnt = tc_now ? per : cnt - 16'h0001;
      end
    end
    // A period ends on the step that lands on zero.
    pend = adv && !tc_now && next_cnt == 16'h0000;
    next_state = state;
    unique case (state)
      cpg_pkg::CPG_ST_IDLE: begin
        if (en && tr_ev) begin
          next_state = cpg_pkg::CPG_ST_RUN;
        end
      end
      cpg_pkg::CPG_ST_RUN: begin
        if (!en) begin
          next_state = cpg_pkg::CPG_ST_IDLE;
        end else if (pend && ctrl.run == cpg_pkg::CPG_SINGLE) begin
          next_state = cpg_pkg::CPG_ST_DONE;
        end else if (pend && ctrl.run == cpg_pkg::CPG_MULTI) begin
          next_state = cpg_pkg::CPG_ST_IDLE;
        end
      end
      cpg_pkg::CPG_ST_DONE: begin
        // Stays stopped until software or hardware drops the enable.
        if (!en) begin
          next_state = cpg_pkg::CPG_ST_IDLE;
        end
      end
      default: next_state = cpg_pkg::CPG_ST_IDLE;
    endcase
    // New compare values only at the boundary, so no runt pulses.
    next_s1 = s1;
    next_s2 = s2;
    if (tc_now) begin
      next_s1 = cmp1;
      if (ctrl.mode == cpg_pkg::CPG_DITHER) begin
        next_s2 = cmp1 + 16'h0001;
      end else begin
        next_s2 = cmp2;
      end
    end
    t1 = cfg.fw ? cfg.t1 : cpg_pkg::FIX_T1;
    t2 = cfg.fw ? cfg.t2 : cpg_pkg::FIX_T2;
    if (ctrl.mode == cpg_pkg::CPG_DITHER) begin
      t2 = t1;
    end
    c1 = cmp_f(cnt, s1, t1);
    c2 = cmp_f(cnt, s2, t2);
    next_dph = pend ? dph + 2'h1 : dph;
    b_raw = 1'b0;
    unique case (ctrl.mode)
      cpg_pkg::CPG_TWO: begin
        a_raw = c1;
        b_raw = c2;
      end
      cpg_pkg::CPG_DUAL: a_raw = c1 & c2;
      cpg_pkg::CPG_DITHER: a_raw = (dph < ctrl.dither) ? c2 : c1;
      cpg_pkg::CPG_HWSEL: a_raw = sel ? c2 : c1;
      default: a_raw = c1;
    endcase
    if (state == cpg_pkg::CPG_ST_IDLE) begin
      a_raw = 1'b0;
      b_raw = 1'b0;
    end
    // Kill handling; a new kill always wins over a release.
    next_kflag = kflag;
    next_kcnt = 8'h00;
    unique case (ctrl.kill)
      cpg_pkg::CPG_K_ASYNC: blk = ks;
      cpg_pkg::CPG_K_CYCLE: begin
        blk = ks | kflag;
        next_kflag = ks | (kflag & ~tc_now);
      end
      cpg_pkg::CPG_K_LATCH: begin
        blk = ks | kflag;
        next_kflag = ks | kflag;
      end
      cpg_pkg::CPG_K_MIN: begin
        blk = ks | (kcnt != 8'h00);
        next_kcnt = ks ? killt : (kcnt != 8'h00 ? kcnt - 8'h01 : 8'h00);
      end
      default: blk = 1'b0;
    endcase
    // Dead band: a phase rises only after the source held steady.
    unique case (cfg.db)
      cpg_pkg::CPG_DB_03: dlen = cpg_pkg::DB03_CYCLES;
      cpg_pkg::CPG_DB_24: dlen = cpg_pkg::DB24_CYCLES;
      default: dlen = {1'b0, dead} + 9'h001;
    endcase
    next_src_q = a_raw;
    if (a_raw != src_q) begin
      next_dbc = 9'h000;
    end else begin
      next_dbc = (dbc == 9'h1ff) ? dbc : dbc + 9'h001;
    end
    next_pa = 1'b0;
    next_pb = 1'b0;
    if (cfg.db != cpg_pkg::CPG_DB_OFF && !blk) begin
      next_pa = a_raw & (next_dbc >= dlen);
      next_pb = ~a_raw & (next_dbc >= dlen);
    end
    next_o1 = a_raw & ~blk;
    next_o2 = b_raw & ~blk;
    next_tc = next_cnt == 16'h0000;
  end

  // Registers only; every pulse output leaves through a flip-flop.
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sync_en <= 3'h0;
      sync_tr <= 3'h0;
      sync_kl <= 3'h0;
      sync_sel <= 3'h0;
      tr_q <= 1'b0;
      state <= cpg_pkg::CPG_ST_IDLE;
      cnt <= 16'h0000;
      up <= 1'b1;
      s1 <= cpg_pkg::RST_CMP1;
      s2 <= cpg_pkg::RST_CMP2;
      dph <= 2'h0;
      kflag <= 1'b0;
      kcnt <= 8'h00;
      src_q <= 1'b0;
      dbc <= 9'h000;
      first_compare_output_out <= 1'b0;
      second_compare_output_out <= 1'b0;
      dead_band_phase_a_out <= 1'b0;
      dead_band_phase_b_out <= 1'b0;
      terminal_count_flag_out <= 1'b1;
    end else begin
      // Pins pass three flip-flops; bit 2 is the only one read.
      sync_en <= {sync_en[1:0], hw_enable_in};
      sync_tr <= {sync_tr[1:0], trigger_in};
      sync_kl <= {sync_kl[1:0], kill_in};
      sync_sel <= {sync_sel[1:0], output_select_in};
      tr_q <= next_tr_q;
      state <= next_state;
      cnt <= next_cnt;
      up <= next_up;
      s1 <= next_s1;
      s2 <= next_s2;
      dph <= next_dph;
      kflag <= next_kflag;
      kcnt <= next_kcnt;
      src_q <= next_src_q;
      dbc <= next_dbc;
      first_compare_output_out <= next_o1;
      second_compare_output_out <= next_o2;
      dead_band_phase_a_out <= next_pa;
      dead_band_phase_b_out <= next_pb;
      terminal_count_flag_out <= next_tc;
    end
  end

  // -----------------------------------------------------------------
  // Assertions and covers.
  // -----------------------------------------------------------------
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);

  AST_TC_ZERO: assert property (terminal_count_flag_out == tc_now)
    else $error("terminal count does not follow zero count");
  AST_DOWN_STEP: assert property (adv && !tc_now &&
    ctrl.mode != cpg_pkg::CPG_CENTER |=> cnt == $past(cnt) - 16'h0001)
    else $error("down count step wrong");
  AST_RELOAD: assert property (adv && tc_now &&
    ctrl.mode != cpg_pkg::CPG_CENTER |=> cnt == $past(per))
    else $error("period not reloaded at zero");
  AST_DUAL: assert property (ctrl.mode == cpg_pkg::CPG_DUAL &&
    state != cpg_pkg::CPG_ST_IDLE && !blk
    |=> first_compare_output_out == ($past(c1) && $past(c2)))
    else $error("dual edge output is not the AND");
  AST_HWSEL: assert property (ctrl.mode == cpg_pkg::CPG_HWSEL &&
    state != cpg_pkg::CPG_ST_IDLE && !blk && sel
    |=> first_compare_output_out == $past(c2))
    else $error("select input high did not route second compare");
  AST_KILL: assert property (ctrl.kill == cpg_pkg::CPG_K_ASYNC && ks
    |=> !first_compare_output_out && !dead_band_phase_a_out)
    else $error("outputs active during kill");
  AST_LATCH: assert property (ctrl.kill == cpg_pkg::CPG_K_LATCH &&
    kflag |=> kflag)
    else $error("latched kill released before reset");
  AST_SINGLE: assert property (state == cpg_pkg::CPG_ST_DONE
    |=> state != cpg_pkg::CPG_ST_RUN)
    else $error("single shot restarted");
  AST_TRIG: assert property (state == cpg_pkg::CPG_ST_IDLE && en &&
    tr_ev |=> state == cpg_pkg::CPG_ST_RUN)
    else $error("trigger did not start the counter");
  AST_DEAD: assert property (!(dead_band_phase_a_out &&
    dead_band_phase_b_out))
    else $error("both phases high");

  COV_PERIOD: cover property (pend ##1 adv [*2]);
  COV_DITHER: cover property (ctrl.mode == cpg_pkg::CPG_DITHER &&
    dph < ctrl.dither && c2);
  COV_LATCH: cover property (ctrl.kill == cpg_pkg::CPG_K_LATCH && kflag);

endmodule

// ### cpg_far_side.sv
`timescale 1ns/1ps
// ------------
// Far side: control pins and a half bridge on the phase pair.
// ------------
module cpg_far_side (
  input wire logic mclk_in,
  input wire logic phase_a_in,
  input wire logic phase_b_in,
  output logic hw_enable_out,
  output logic trigger_out,
  output logic kill_out,
  output logic select_out
);
  // Cycles in which both bridge switches would conduct.
  int shoot_through = 0;

  // Callers run at a rising edge, so pins never move on a sampling edge.
  task automatic drive(input logic en, input logic tr, input logic kl,
                       input logic sl);
    hw_enable_out <= en;
    trigger_out <= tr;
    kill_out <= kl;
    select_out <= sl;
  endtask

  // A real bridge would short here, so every such cycle is recorded.
  always @(posedge mclk_in) begin
    if (phase_a_in === 1'b1 && phase_b_in === 1'b1) begin
      shoot_through <= shoot_through + 1;
    end
  end
endmodule

// ### tb_top.sv
`timescale 1ns/1ps
// ------------
// Self-checking bench for the pulse generator.
// ------------
module tb_top;
  localparam int P = 9; // Short period keeps windows small.
  localparam int C1 = 4;
  localparam int C2 = 6;
  localparam int PD = 29; // Longer period leaves room for dead time.
  localparam int CD = 15;
  localparam int HI = 3 * (P - C1); // Greater-than highs in 3 periods.
  // One case: set-up values beside expected high-cycle counts.
  typedef struct {
    logic [15:0] ctl;
    logic [15:0] cfg;
    logic s;
    int per, cmp, cyc, ntc, e1, e2, ea;
  } cpg_row_t;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] addr_in = 8'h00;
  logic [15:0] wr_data_in = 16'h0000;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic [15:0] rd_data_out;
  logic hw_enable_in, trigger_in, kill_in, output_select_in;
  logic first_compare_output_out, second_compare_output_out;
  logic dead_band_phase_a_out, dead_band_phase_b_out;
  logic terminal_count_flag_out;
  logic lv; // Trigger level before the starting edge.
  int n_fail = 0;
  int tests_run = 0;
  int n1, n2, na, nb, nt; // High cycles of each output in a window.
  // A value of -1 means the output is not judged in that case.
  cpg_row_t rows[17] = '{
    '{16'h0001, 16'h0000, 0, P, C1, P+1, 1, C1, 0, 0},
    '{16'h8001, 16'h0000, 0, P, C1, P+1, 1, C1, -1, -1},
    '{16'h0003, 16'h0040, 0, P, C1, P+1, 1, C1, C2, -1},
    '{16'h0003, 16'h0051, 0, P, C1, P+1, 1, C1+1, P-C2, -1},
    '{16'h0003, 16'h0063, 0, P, C1, P+1, 1, P-C1+1, 1, -1},
    '{16'h0003, 16'h0011, 0, P, C1, P+1, 1, C1, C2, -1},
    '{16'h0005, 16'h0000, 0, P, C1, P+1, 1, C1, -1, -1},
    '{16'h000b, 16'h0000, 0, P, C1, P+1, 1, C1, -1, -1},
    '{16'h000b, 16'h0000, 1, P, C1, P+1, 1, C2, -1, -1},
    '{16'h0007, 16'h0000, 0, P, C1, 2*P, 1, 2*C1-1, -1, -1},
    '{16'h0009, 16'h0000, 0, P, C1, 4*P+4, 4, 4*C1, -1, -1},
    '{16'h2009, 16'h0000, 0, P, C1, 4*P+4, 4, 4*C1+1, -1, -1},
    '{16'h4009, 16'h0000, 0, P, C1, 4*P+4, 4, 4*C1+2, -1, -1},
    '{16'h6009, 16'h0000, 0, P, C1, 4*P+4, 4, 4*C1+3, -1, -1},
    '{16'h0001, 16'h0080, 0, PD, CD, PD+1, 1, CD, -1, CD-3},
    '{16'h0001, 16'h0100, 0, PD, CD, PD+1, 1, CD, -1, CD-2},
    '{16'h0001, 16'h0180, 0, PD, CD, PD+1, 1, CD, -1, CD-5}
  };

  cpg_top dut (.mclk_in, .rst_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
    .rd_data_out, .hw_enable_in, .trigger_in, .kill_in, .output_select_in,
    .first_compare_output_out, .second_compare_output_out,
    .dead_band_phase_a_out, .dead_band_phase_b_out,
    .terminal_count_flag_out);
  cpg_far_side far (.mclk_in, .phase_a_in(dead_band_phase_a_out),
    .phase_b_in(dead_band_phase_b_out), .hw_enable_out(hw_enable_in),
    .trigger_out(trigger_in), .kill_out(kill_in),
    .select_out(output_select_in));

  // Half period of 5 ns gives the 100 MHz clock.
  always #5 mclk_in = ~mclk_in;

  // ------------
  // Shared tasks; each starts and ends at a rising edge.
  // ------------
  task automatic check(input int got, input int exp);
    tests_run++;
    if (got != exp) begin
      n_fail++;
      $display("BAD %0t count %0d expected %0d", $time, got, exp);
    end
  endtask

  // The trailing idle cycle stops two strobes landing in one time step.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    addr_in <= a;
    wr_data_in <= d;
    wr_in <= 1'b1;
    @(posedge mclk_in);
    wr_in <= 1'b0;
    @(posedge mclk_in);
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    tests_run++;
    if (rd_data_out !== e) begin
      n_fail++;
      $display("BAD %0t read %h gave %h", $time, a, rd_data_out);
    end
    @(posedge mclk_in);
  endtask

  // Counts high cycles over n cycles once w cycles have passed.
  task automatic measure(input int w, input int n);
    {n1, n2, na, nb, nt} = 160'h0;
    repeat (w) @(posedge mclk_in);
    repeat (n) begin
      #1;
      n1 += int'(first_compare_output_out === 1'b1);
      n2 += int'(second_compare_output_out === 1'b1);
      na += int'(dead_band_phase_a_out === 1'b1);
      nb += int'(dead_band_phase_b_out === 1'b1);
      nt += int'(terminal_count_flag_out === 1'b1);
      @(posedge mclk_in);
    end
  endtask

  // Bounded wait for the zero flag to rise, so windows start in step.
  task automatic sync_period();
    logic last;
    last = 1'b1;
    repeat (3000) begin
      #1;
      if (terminal_count_flag_out === 1'b1 && last === 1'b0) break;
      last = terminal_count_flag_out;
      @(posedge mclk_in);
    end
    @(posedge mclk_in);
  endtask

  // Resets the block, loads values and restarts; the wait covers pin
  // synchronisers and a period boundary for the compare shadows.
  task automatic setup(input logic [15:0] cfg, input int per,
                       input int cmp, input logic [15:0] ctl);
    // A disable alone leaves the count where it stopped, which would
    // cut short the first period of a one-shot run.
    rst_in <= 1'b1;
    @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    wr(cpg_pkg::A_CTRL, 16'h0000);
    wr(cpg_pkg::A_CFG, cfg);
    wr(cpg_pkg::A_DEAD, 16'h0004);
    wr(cpg_pkg::A_PERIOD, 16'(per));
    wr(cpg_pkg::A_CMP1, 16'(cmp));
    wr(cpg_pkg::A_CMP2, 16'(C2));
    wr(cpg_pkg::A_CTRL, ctl);
    repeat (40) @(posedge mclk_in);
  endtask

  task automatic tally_and_finish();
    if (n_fail == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------
  // Main sequence.
  // ------------
  initial begin
    far.drive(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (16) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    foreach (rows[i]) begin
      far.drive(1'b0, 1'b0, 1'b0, rows[i].s);
      setup(rows[i].cfg, rows[i].per, rows[i].cmp, rows[i].ctl);
      sync_period();
      measure(0, rows[i].cyc);
      check(n1, rows[i].e1);
      check(nt, rows[i].ntc);
      if (rows[i].e2 >= 0) begin
        check(n2, rows[i].e2);
      end
      if (rows[i].ea >= 0) begin
        check(na, rows[i].ea);
        check(nb, rows[i].ea);
      end
    end
    check(far.shoot_through, 0);
    // Hardware-only enable follows the pin; both needs bit and pin.
    setup(16'h0042, P, C1, 16'h0010);
    measure(0, 30);
    check(n1, 0);
    far.drive(1'b1, 1'b0, 1'b0, 1'b0);
    measure(20, 30);
    check(n1, HI);
    setup(16'h0042, P, C1, 16'h0020);
    measure(0, 30);
    check(n1, 0);
    setup(16'h0042, P, C1, 16'h0021);
    measure(0, 30);
    check(n1, HI);
    // Single shot on each edge kind: nothing before, one period after.
    for (int m = 1; m < 4; m++) begin
      lv = (m == 2);
      far.drive(1'b0, lv, 1'b0, 1'b0);
      setup(16'h0042, P, C1, 16'h0041 | (16'(m) << 8));
      measure(0, 30);
      check(n1, 0);
      far.drive(1'b0, ~lv, 1'b0, 1'b0);
      measure(0, 60);
      check(n1, P - C1);
    end
    // Multi shot on either edge runs one period per edge.
    setup(16'h0042, P, C1, 16'h0381);
    far.drive(1'b0, 1'b0, 1'b0, 1'b0);
    measure(0, 60);
    check(n1, P - C1);
    far.drive(1'b0, 1'b1, 1'b0, 1'b0);
    measure(0, 60);
    check(n1, P - C1);
    // Continuous on a rising edge keeps running.
    far.drive(1'b0, 1'b0, 1'b0, 1'b0);
    setup(16'h0042, P, C1, 16'h0101);
    far.drive(1'b0, 1'b1, 1'b0, 1'b0);
    measure(20, 30);
    check(n1, HI);
    // Asynchronous kill blocks only while the pin is high.
    setup(16'h0042, P, C1, 16'h0401);
    far.drive(1'b0, 1'b0, 1'b1, 1'b0);
    measure(10, 30);
    check(n1, 0);
    far.drive(1'b0, 1'b0, 1'b0, 1'b0);
    measure(10, 30);
    check(n1, HI);
    // Single-cycle kill dropped just after zero waits for the next zero.
    setup(16'h0042, P, C1, 16'h0801);
    far.drive(1'b0, 1'b0, 1'b1, 1'b0);
    sync_period();
    sync_period();
    far.drive(1'b0, 1'b0, 1'b0, 1'b0);
    measure(0, 8);
    check(n1, 0);
    measure(20, 30);
    check(n1, HI);
    // Minimum-time kill stays off for the programmed count after release.
    setup(16'h0042, P, C1, 16'h1001);
    wr(cpg_pkg::A_KILLT, 16'h0064);
    far.drive(1'b0, 1'b0, 1'b1, 1'b0);
    measure(5, 0);
    far.drive(1'b0, 1'b0, 1'b0, 1'b0);
    measure(10, 60);
    check(n1, 0);
    measure(60, 30);
    check(n1, HI);
    // Latched kill holds after the pin drops; only reset ends it.
    setup(16'h0042, P, C1, 16'h0c01);
    far.drive(1'b0, 1'b0, 1'b1, 1'b0);
    measure(5, 0);
    far.drive(1'b0, 1'b0, 1'b0, 1'b0);
    measure(10, 60);
    check(n1, 0);
    // Reset in mid-run, then reset values, masking and refusals.
    rst_in <= 1'b1;
    repeat (3) @(posedge mclk_in);
    rst_in <= 1'b0;
    @(posedge mclk_in);
    rd(cpg_pkg::A_CTRL, 16'h0000);
    rd(cpg_pkg::A_PERIOD, cpg_pkg::RST_PERIOD);
    rd(cpg_pkg::A_CMP1, cpg_pkg::RST_CMP1);
    rd(cpg_pkg::A_CMP2, cpg_pkg::RST_CMP2);
    rd(cpg_pkg::A_KILLT, 16'(cpg_pkg::RST_KILLT));
    rd(cpg_pkg::A_STAT, 16'h0001);
    wr(cpg_pkg::A_DEAD, 16'h0007);
    rd(cpg_pkg::A_DEAD, 16'h0000);
    wr(cpg_pkg::A_CFG, 16'hff80);
    rd(cpg_pkg::A_CFG, 16'h0180);
    wr(cpg_pkg::A_DEAD, 16'h0007);
    rd(cpg_pkg::A_DEAD, 16'h0007);
    wr(cpg_pkg::A_COUNT, 16'h0005);
    rd(cpg_pkg::A_COUNT, 16'h0000);
    wr(8'h24, 16'h1234);
    rd(8'h24, 16'h0000);
    tally_and_finish();
  end

  // The sequence needs under 8000 cycles; 40000 means a hang.
  initial begin
    repeat (40000) @(posedge mclk_in);
    n_fail++;
    $display("BAD %0t watchdog expired", $time);
    tally_and_finish();
  end
endmodule
